//--- core/bpcmp_top.sv
// What this block does
// - first comparator masks: full, 256B, 16KB
// - second comparator dual mode: same masks
// - extended compare only when program page selected
// - full mode data byte masks on B
// - full mode: B extended bits ignored
// - debug mode: bits 7:6 select paging
// - upper select bit ignored
// - legacy: extended vs program_page on flash
// - legacy flash: high bits 5:0 vs 13:8
// - debug sel 01: 21:16, high 15:14+13:8
// - each compare bit equals bus bit
// - extended bits compared to page signals
// - address mask code 1:0 acts as full compare
`include "bpcmp_regs.svh"
`default_nettype none
module bpcmp_top
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// core bus, same clock
	input wire bpcmp_pkg::bpcmp_bus_t bus_i,
	// results
	output logic match_a_o,
	output logic match_b_o,
	output logic irq_o
);
	logic [7:0] ctrl;
	bpcmp_pkg::bpcmp_cmp_t ca;
	bpcmp_pkg::bpcmp_cmp_t cb;
	logic [1:0] stat;
	logic [1:0] mask;
	logic hit_a;
	logic hit_b;
	logic wr;
	logic wr_lo;
	logic [31:0] next_dat;

	// ----------------------------------------
	// address and data comparison
	// ----------------------------------------
	// returns 1 on a match of compare word c against the bus, using mask code hm:lm
	function automatic logic addr_match(
		input bpcmp_pkg::bpcmp_cmp_t c,
		input logic hm,
		input logic lm,
		input logic trace_en,
		input bpcmp_pkg::bpcmp_bus_t b
	);
		logic use_low;
		logic use_high;
		logic use_ext;
		logic ok_ext;
		logic ok_high;
		logic ok_low;
		bpcmp_pkg::bpcmp_page_t kind;
		use_low = ~lm;
		use_high = ~lm | ~hm; // 1:0 forced to full
		kind = bpcmp_pkg::bpcmp_page_t'({1'b0, c.ext[`BPCMP_X_SEL_LO]});
		ok_ext = 1'b1;
		ok_high = (c.high == b.cpu_address_bus[15:8]);
		if (trace_en)
		begin
			use_ext = (kind == bpcmp_pkg::BPCMP_PG_PROG) && b.prog_page;
			if (use_ext)
			begin
				ok_ext = (c.ext[5:0] == b.expanded_address_bus[21:16]);
				ok_high = (c.high == {b.expanded_address_bus[15:14],
					b.cpu_address_bus[13:8]});
			end
		end
		else
		begin
			// select field unused here
			use_ext = b.flash_rom && b.prog_page;
			if (use_ext)
			begin
				ok_ext = (c.ext[5:0] == b.program_page);
				ok_high = (c.high[5:0] == b.cpu_address_bus[13:8]);
			end
		end
		ok_low = (c.low == b.cpu_address_bus[7:0]);
		addr_match = ok_ext & (ok_high | ~use_high) & (ok_low | ~use_low);
	endfunction : addr_match

	// data compare on B in full mode; extended bits unused
	function automatic logic data_match(
		input bpcmp_pkg::bpcmp_cmp_t c,
		input logic hm,
		input logic lm,
		input logic [15:0] d
	);
		data_match = ((c.high == d[15:8]) | hm) & ((c.low == d[7:0]) | lm);
	endfunction : data_match

	always_comb
	begin
		hit_a = bus_i.valid & addr_match(ca, ctrl[`BPCMP_CTRL_A_HI], ctrl[`BPCMP_CTRL_A_LO],
			ctrl[`BPCMP_CTRL_TRACE_EN], bus_i);
		if (ctrl[`BPCMP_CTRL_FULL])
			hit_b = hit_a & data_match(cb, ctrl[`BPCMP_CTRL_B_HI], ctrl[`BPCMP_CTRL_B_LO],
				bus_i.data);
		else
			hit_b = bus_i.valid & addr_match(cb, ctrl[`BPCMP_CTRL_B_HI],
				ctrl[`BPCMP_CTRL_B_LO], ctrl[`BPCMP_CTRL_TRACE_EN], bus_i);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			match_a_o <= 1'b0;
			match_b_o <= 1'b0;
		end
		else
		begin
			match_a_o <= hit_a;
			match_b_o <= hit_b;
		end
	end

	// ----------------------------------------
	// wishbone slave, one wait state
	// ----------------------------------------
	assign wr = cyc_i & stb_i & we_i & ~ack_o;
	assign wr_lo = wr & sel_i[0];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_o <= 1'b0;
		else
			ack_o <= cyc_i & stb_i & ~ack_o;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl <= `BPCMP_RST_BYTE;
			ca <= {3{`BPCMP_RST_BYTE}};
			cb <= {3{`BPCMP_RST_BYTE}};
			mask <= `BPCMP_RST_BITS;
		end
		else if (wr_lo)
		begin
			case (adr_i)
				`BPCMP_OFS_CTRL: ctrl <= {2'h0, dat_i[5:0]};
				`BPCMP_OFS_CAX: ca.ext <= dat_i[7:0];
				`BPCMP_OFS_CAH: ca.high <= dat_i[7:0];
				`BPCMP_OFS_CAL: ca.low <= dat_i[7:0];
				`BPCMP_OFS_CBX: cb.ext <= dat_i[7:0];
				`BPCMP_OFS_CBH: cb.high <= dat_i[7:0];
				`BPCMP_OFS_CBL: cb.low <= dat_i[7:0];
				`BPCMP_OFS_MASK: mask <= dat_i[1:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// sticky status, write one to clear
	// ----------------------------------------
	// set wins over a clear in the same cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			stat <= `BPCMP_RST_BITS;
		else if (wr_lo && adr_i == `BPCMP_OFS_STAT)
			stat <= (stat & ~dat_i[1:0]) | {hit_b, hit_a};
		else
			stat <= stat | {hit_b, hit_a};
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(stat & mask);
	end

	always_comb
	begin
		case (adr_i)
			`BPCMP_OFS_CTRL: next_dat = {24'h0, ctrl};
			`BPCMP_OFS_CAX: next_dat = {24'h0, ca.ext};
			`BPCMP_OFS_CAH: next_dat = {24'h0, ca.high};
			`BPCMP_OFS_CAL: next_dat = {24'h0, ca.low};
			`BPCMP_OFS_CBX: next_dat = {24'h0, cb.ext};
			`BPCMP_OFS_CBH: next_dat = {24'h0, cb.high};
			`BPCMP_OFS_CBL: next_dat = {24'h0, cb.low};
			`BPCMP_OFS_STAT: next_dat = {30'h0, stat};
			`BPCMP_OFS_MASK: next_dat = {30'h0, mask};
			default: next_dat = 32'h0;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_o <= 32'h0;
		else
			dat_o <= next_dat;
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	AST_RANGE_16K: assert property (@(posedge clk_i) disable iff (rst_i)
		(bus_i.valid && ctrl[3:2] == 2'b11 && !ctrl[0] && !bus_i.flash_rom) |=> match_a_o)
		else $error("16K range must match any non-paged address");
	AST_FORCE_FULL: assert property (@(posedge clk_i) disable iff (rst_i)
		(!ctrl[0] && ctrl[3:2] == 2'b10 && !bus_i.flash_rom
		&& bus_i.cpu_address_bus[15:8] != ca.high)
		|=> !match_a_o)
		else $error("mask 1:0 must still compare high byte");
	AST_LOW_MASK: assert property (@(posedge clk_i) disable iff (rst_i)
		(!ctrl[1] && !ctrl[4] && bus_i.cpu_address_bus[7:0] != cb.low) |=> !match_b_o)
		else $error("B low byte mismatch must block match");
	AST_DATA_NONE: assert property (@(posedge clk_i) disable iff (rst_i)
		(ctrl[1] && ctrl[5:4] == 2'b11) |=> (match_b_o == match_a_o))
		else $error("data mask 1:1 must follow address match");
	AST_DATA_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
		(ctrl[1] && !ctrl[5] && bus_i.data[15:8] != cb.high) |=> !match_b_o)
		else $error("data high byte mismatch must block");
	AST_LEGACY_EXT: assert property (@(posedge clk_i) disable iff (rst_i)
		(!ctrl[0] && bus_i.flash_rom && bus_i.prog_page && bus_i.program_page != ca.ext[5:0])
		|=> !match_a_o)
		else $error("legacy extended mismatch must block");
	AST_NOPAGE: assert property (@(posedge clk_i) disable iff (rst_i)
		(ctrl[0] && !bus_i.prog_page && bus_i.valid && ctrl[3:2] == 2'b11) |=> match_a_o)
		else $error("extended compare used without program page");
	AST_SEL_UPPER: assert property (@(posedge clk_i) disable iff (rst_i)
		(ctrl[0] && ca.ext[7:6] == 2'b10 && bus_i.valid && ctrl[3:2] == 2'b11) |=> match_a_o)
		else $error("select 10 must act as 00");
	AST_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
		match_a_o |-> stat[0])
		else $error("status A not set on match");
	AST_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
		(|(stat & mask)) |=> irq_o)
		else $error("interrupt not raised");

	// ----------------------------------------
	// first comparator, address masks
	// ----------------------------------------
	// a hit is only promised on a valid cycle; idle cycles carry junk
	AST_A_EXACT: assert property (@(posedge clk_i) disable iff (rst_i)
		(bus_i.valid && !ctrl[0] && ctrl[3:2] == 2'b00 && !bus_i.flash_rom
		&& bus_i.cpu_address_bus == {ca.high, ca.low})
		|=> match_a_o)
		else $error("exact address did not hit on A");
	AST_A_LOW_CMP: assert property (@(posedge clk_i) disable iff (rst_i)
		(!ctrl[2] && bus_i.cpu_address_bus[7:0] != ca.low)
		|=> !match_a_o)
		else $error("A low byte mismatch must block");
	AST_A_RANGE_256: assert property (@(posedge clk_i) disable iff (rst_i)
		(bus_i.valid && !ctrl[0] && ctrl[3:2] == 2'b01 && !bus_i.flash_rom
		&& bus_i.cpu_address_bus[15:8] == ca.high)
		|=> match_a_o)
		else $error("256 byte range on A missed");
	AST_A_HIGH_CMP: assert property (@(posedge clk_i) disable iff (rst_i)
		(!ctrl[0] && ctrl[3:2] == 2'b01 && !bus_i.flash_rom
		&& bus_i.cpu_address_bus[15:8] != ca.high)
		|=> !match_a_o)
		else $error("A high byte mismatch must block");

	// ----------------------------------------
	// second comparator, dual mode
	// ----------------------------------------
	AST_B_RANGE_256: assert property (@(posedge clk_i) disable iff (rst_i)
		(bus_i.valid && ctrl[1:0] == 2'b00 && ctrl[5:4] == 2'b01 && !bus_i.flash_rom
		&& bus_i.cpu_address_bus[15:8] == cb.high)
		|=> match_b_o)
		else $error("256 byte range on B missed");
	AST_B_RANGE_16K: assert property (@(posedge clk_i) disable iff (rst_i)
		(bus_i.valid && ctrl[1:0] == 2'b00 && ctrl[5:4] == 2'b11 && !bus_i.flash_rom)
		|=> match_b_o)
		else $error("16K range on B missed");
	AST_B_HIGH_CMP: assert property (@(posedge clk_i) disable iff (rst_i)
		(ctrl[1:0] == 2'b00 && ctrl[5:4] != 2'b11 && !bus_i.flash_rom
		&& bus_i.cpu_address_bus[15:8] != cb.high)
		|=> !match_b_o)
		else $error("B high byte mismatch must block");

	// ----------------------------------------
	// paged compares
	// ----------------------------------------
	// legacy ignores address bits 15:14 on flash, so pages can alias
	AST_LEGACY_HIT: assert property (@(posedge clk_i) disable iff (rst_i)
		(bus_i.valid && !ctrl[0] && ctrl[3:2] == 2'b00 && bus_i.flash_rom
		&& bus_i.prog_page && bus_i.program_page == ca.ext[5:0]
		&& bus_i.cpu_address_bus[13:0] == {ca.high[5:0], ca.low})
		|=> match_a_o)
		else $error("legacy paged address missed");
	AST_LEGACY_NOFLASH: assert property (@(posedge clk_i) disable iff (rst_i)
		(!ctrl[0] && ctrl[3:2] == 2'b00 && !bus_i.flash_rom
		&& bus_i.cpu_address_bus[15:8] != ca.high)
		|=> !match_a_o)
		else $error("legacy non-flash must compare all high bits");
	AST_DBG_HIT: assert property (@(posedge clk_i) disable iff (rst_i)
		(bus_i.valid && ctrl[0] && ctrl[3:2] == 2'b00 && ca.ext[6] && bus_i.prog_page
		&& bus_i.expanded_address_bus == {ca.ext[5:0], ca.high[7:6]}
		&& bus_i.cpu_address_bus[13:0] == {ca.high[5:0], ca.low})
		|=> match_a_o)
		else $error("paged debug address missed");
	AST_DBG_EXT_MISS: assert property (@(posedge clk_i) disable iff (rst_i)
		(ctrl[0] && ca.ext[6] && bus_i.prog_page
		&& bus_i.expanded_address_bus[21:16] != ca.ext[5:0])
		|=> !match_a_o)
		else $error("page mismatch must block in debug mode");
	AST_SEL_PAGED: assert property (@(posedge clk_i) disable iff (rst_i)
		(ctrl[0] && ca.ext[7:6] == 2'b11 && bus_i.prog_page
		&& bus_i.expanded_address_bus[21:16] != ca.ext[5:0])
		|=> !match_a_o)
		else $error("select 11 must act as 01");
	AST_DBG_NONE: assert property (@(posedge clk_i) disable iff (rst_i)
		(ctrl[0] && !ca.ext[6] && ctrl[3:2] == 2'b00
		&& bus_i.cpu_address_bus[15:8] != ca.high)
		|=> !match_a_o)
		else $error("select 00 must compare all high bits");

	// ----------------------------------------
	// full mode and qualifiers
	// ----------------------------------------
	AST_FULL_B_EXT: assert property (@(posedge clk_i) disable iff (rst_i)
		(bus_i.valid && ctrl[1:0] == 2'b10 && ctrl[5:2] == 4'h0 && !bus_i.flash_rom
		&& bus_i.cpu_address_bus == {ca.high, ca.low}
		&& bus_i.data == {cb.high, cb.low})
		|=> match_b_o)
		else $error("full mode hit blocked by B page bits");
	AST_DATA_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
		(ctrl[1] && !ctrl[4] && bus_i.data[7:0] != cb.low)
		|=> !match_b_o)
		else $error("data low byte mismatch must block");
	AST_FULL_NEEDS_A: assert property (@(posedge clk_i) disable iff (rst_i)
		(ctrl[1] && !ctrl[2] && bus_i.cpu_address_bus[7:0] != ca.low)
		|=> !match_b_o)
		else $error("full mode data hit needs address hit");
	AST_VALID_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
		!bus_i.valid |=> (!match_a_o && !match_b_o))
		else $error("idle core cycle must not match");
endmodule : bpcmp_top
`default_nettype wire

//--- shared/bpcmp_regs.svh
`ifndef BPCMP_REGS_SVH
`define BPCMP_REGS_SVH
// ----------------------------------------
// register word offsets (byte addresses)
// ----------------------------------------
`define BPCMP_OFS_CTRL 8'h00
`define BPCMP_OFS_CAX 8'h04
`define BPCMP_OFS_CAH 8'h08
`define BPCMP_OFS_CAL 8'h0c
`define BPCMP_OFS_CBX 8'h10
`define BPCMP_OFS_CBH 8'h14
`define BPCMP_OFS_CBL 8'h18
`define BPCMP_OFS_STAT 8'h1c
`define BPCMP_OFS_MASK 8'h20
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define BPCMP_CTRL_TRACE_EN 0
`define BPCMP_CTRL_FULL 1
`define BPCMP_CTRL_A_LO 2
`define BPCMP_CTRL_A_HI 3
`define BPCMP_CTRL_B_LO 4
`define BPCMP_CTRL_B_HI 5
`define BPCMP_X_SEL_LO 6
`define BPCMP_STAT_A 0
`define BPCMP_STAT_B 1
`define BPCMP_RST_BYTE 8'h00
`define BPCMP_RST_BITS 2'h0
`endif

//--- shared/bpcmp_pkg.sv
`default_nettype none
package bpcmp_pkg;
	// core bus sample, one cycle of address and data
	typedef struct packed {
		logic valid;
		logic prog_page;
		logic flash_rom;
		logic [5:0] program_page;
		logic [21:14] expanded_address_bus;
		logic [15:0] cpu_address_bus;
		logic [15:0] data;
	} bpcmp_bus_t;
	typedef struct packed {
		logic [7:0] ext;
		logic [7:0] high;
		logic [7:0] low;
	} bpcmp_cmp_t;
	typedef enum logic [1:0] {
		BPCMP_PG_NONE = 2'b00,
		BPCMP_PG_PROG = 2'b01,
		BPCMP_PG_DATA = 2'b10,
		BPCMP_PG_EEP = 2'b11
	} bpcmp_page_t;
endpackage : bpcmp_pkg
`default_nettype wire

//--- dv/bpcmp_core_model.sv
`default_nettype none
module bpcmp_core_model
(
	// clock
	input wire logic clk_i,
	// core bus toward the comparators
	output var bpcmp_pkg::bpcmp_bus_t bus_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial bus_o = '0;
	// one core bus cycle; then junk with valid low, so stale lines never match
	task put(input bpcmp_pkg::bpcmp_bus_t b);
		@(posedge clk_i);
		bus_o <= b;
		@(posedge clk_i);
		bus_o <= {1'b0, ~b[47:0]};
		#1;
	endtask : put
endmodule : bpcmp_core_model
`default_nettype wire

//--- dv/bpcmp_top_test.sv
`default_nettype none
module bpcmp_top_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [3:0] sel = 4'h1;
	logic [31:0] q;
	logic [31:0] rdat;
	logic ack, ma, mb, irq;
	bpcmp_pkg::bpcmp_bus_t bus;
	int n_mismatch = 0;
	int checks_done = 0;
	always #12.5 clk_i = ~clk_i;
	bpcmp_core_model core (.clk_i(clk_i), .bus_o(bus));
	bpcmp_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(cyc), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(q), .ack_o(ack), .bus_i(bus),
		.match_a_o(ma), .match_b_o(mb), .irq_o(irq));
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask : chk
	// classic single cycle; waits on ack, watchdog cuts a hang
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		{cyc, we, adr, dat} <= {1'b1, w, a, 24'h0, d};
		@(posedge clk_i);
		while (ack !== 1'b1)
			@(posedge clk_i);
		rdat = q;
		cyc <= 1'b0;
	endtask : wb
	task rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 8'h00);
		chk("reg", e, rdat);
	endtask : rd
	task hit(input logic [1:0] pf, input logic [5:0] pg, input logic [7:0] x,
		input logic [15:0] ab, input logic [15:0] d, input logic [1:0] e);
		core.put({1'b1, pf, pg, x, ab, d});
		chk("match", e, {ma, mb});
	endtask : hit
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		#50us;
		n_mismatch++;
		tally_and_finish;
	end
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h04, 32'h0);
		wb(1'b1, 8'h04, 8'h05);
		wb(1'b1, 8'h08, 8'h12);
		wb(1'b1, 8'h0c, 8'h34);
		wb(1'b1, 8'h14, 8'h56);
		wb(1'b1, 8'h18, 8'h78);
		wb(1'b1, 8'h24, 8'hff);
		rd(8'h24, 32'h0);
		rd(8'h08, 32'h12);
		hit(2'h0, 6'h00, 8'h00, 16'h1234, 16'h0, 2'h2);
		hit(2'h0, 6'h00, 8'h00, 16'h1634, 16'h0, 2'h0);
		wb(1'b1, 8'h00, 8'h04);
		hit(2'h0, 6'h00, 8'h00, 16'h12ff, 16'h0, 2'h2);
		hit(2'h0, 6'h00, 8'h00, 16'h13ff, 16'h0, 2'h0);
		wb(1'b1, 8'h00, 8'h0c);
		hit(2'h0, 6'h00, 8'h00, 16'habcd, 16'h0, 2'h2);
		wb(1'b1, 8'h00, 8'h08);
		hit(2'h0, 6'h00, 8'h00, 16'h12ff, 16'h0, 2'h0);
		wb(1'b1, 8'h00, 8'h10);
		hit(2'h0, 6'h00, 8'h00, 16'h56aa, 16'h0, 2'h1);
		wb(1'b1, 8'h00, 8'h30);
		hit(2'h0, 6'h00, 8'h00, 16'h1111, 16'h0, 2'h1);
		wb(1'b1, 8'h00, 8'h00);
		hit(2'h3, 6'h05, 8'h00, 16'hd234, 16'h0, 2'h2);
		hit(2'h3, 6'h06, 8'h00, 16'hd234, 16'h0, 2'h0);
		hit(2'h2, 6'h05, 8'h00, 16'hd234, 16'h0, 2'h0);
		hit(2'h1, 6'h05, 8'h00, 16'hd234, 16'h0, 2'h0);
		wb(1'b1, 8'h04, 8'h45);
		hit(2'h3, 6'h05, 8'h00, 16'hd234, 16'h0, 2'h2);
		wb(1'b1, 8'h00, 8'h01);
		hit(2'h3, 6'h00, 8'h14, 16'hd234, 16'h0, 2'h2);
		hit(2'h3, 6'h00, 8'h18, 16'hd234, 16'h0, 2'h0);
		hit(2'h3, 6'h00, 8'h15, 16'hd234, 16'h0, 2'h0);
		hit(2'h1, 6'h00, 8'h14, 16'hd234, 16'h0, 2'h0);
		wb(1'b1, 8'h04, 8'hc5);
		hit(2'h3, 6'h00, 8'h14, 16'hd234, 16'h0, 2'h2);
		hit(2'h3, 6'h00, 8'h18, 16'hd234, 16'h0, 2'h0);
		wb(1'b1, 8'h04, 8'h85);
		hit(2'h3, 6'h00, 8'h14, 16'h1234, 16'h0, 2'h2);
		hit(2'h3, 6'h00, 8'h14, 16'hd234, 16'h0, 2'h0);
		wb(1'b1, 8'h00, 8'h02);
		wb(1'b1, 8'h10, 8'h3f);
		hit(2'h0, 6'h00, 8'h00, 16'h1234, 16'h5678, 2'h3);
		hit(2'h0, 6'h00, 8'h00, 16'h1234, 16'h5679, 2'h2);
		wb(1'b1, 8'h00, 8'h12);
		hit(2'h0, 6'h00, 8'h00, 16'h1234, 16'h56ff, 2'h3);
		hit(2'h0, 6'h00, 8'h00, 16'h1234, 16'h5778, 2'h2);
		wb(1'b1, 8'h00, 8'h22);
		hit(2'h0, 6'h00, 8'h00, 16'h1234, 16'hff78, 2'h3);
		wb(1'b1, 8'h00, 8'h32);
		hit(2'h0, 6'h00, 8'h00, 16'h1234, 16'h0000, 2'h3);
		rd(8'h1c, 32'h3);
		chk("irq", 32'h0, {31'h0, irq});
		wb(1'b1, 8'h20, 8'h02);
		@(posedge clk_i);
		#1;
		chk("irq", 32'h1, {31'h0, irq});
		wb(1'b1, 8'h1c, 8'h02);
		rd(8'h1c, 32'h1);
		chk("irq", 32'h0, {31'h0, irq});
		tally_and_finish;
	end
endmodule : bpcmp_top_test
`default_nettype wire
